// ==== ctbsa_pkg.sv ====
package ctbsa_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_EMPTY_FLAGS = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLES = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_ABORT_REQS = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_ABORT_ACKS = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_SENSITIVITY = 5'h18;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int NUM_BUF = 3;
	localparam logic [NUM_BUF-1:0] RST_EMPTY_FLAGS = 3'h7;
	localparam logic [NUM_BUF-1:0] RST_IRQ_ENABLES = 3'h0;
	localparam logic [NUM_BUF-1:0] RST_ABORT_REQS = 3'h0;
	localparam logic [NUM_BUF-1:0] RST_ABORT_ACKS = 3'h0;
	localparam logic [3:0] RST_CONTROL = 4'h1;
	localparam logic [3:0] RST_SENSITIVITY = 4'h0;
	localparam int CTL_INIT_REQ = 0;
	localparam int CTL_LISTEN = 1;
	localparam int CTL_WAKE_IRQ_EN = 2;
	localparam int CTL_WAKE_FN_EN = 3;
	localparam int STA_INIT_ACK = 0;
	localparam int STA_RX_LSB = 2;
	localparam int STA_TX_LSB = 4;
	localparam int STA_CHANGE_FLAG = 6;
	localparam int SENS_TX_LSB = 2;
	localparam int SENS_RX_LSB = 4;

	// ------------------------------------------------------------
	// Error state codes and sensitivity levels
	// ------------------------------------------------------------
	localparam logic [1:0] ST_OK = 2'h0;
	localparam logic [1:0] ST_WARN = 2'h1;
	localparam logic [1:0] ST_ERR = 2'h2;
	localparam logic [1:0] ST_BUS_OFF = 2'h3;
	localparam logic [1:0] SENS_NONE = 2'h0;
	localparam logic [1:0] SENS_BUS_OFF = 2'h1;
	localparam logic [1:0] SENS_ERR = 2'h2;
	localparam logic [1:0] SENS_ALL = 2'h3;

endpackage

// ==== ctbsa_top.sv ====
// Summary of operation
// - One empty flag per transmit buffer; 1 empty, 0 holds a message awaiting send.
// - Successful transmission of a buffer's message sets its empty flag.
// - A granted abort of a buffer's transmission also sets its empty flag.
// - Empty flag and its enable both set keep that buffer's interrupt pending.
// - Clearing an empty flag also clears that buffer's abort acknowledge.
// - Setting an empty flag clears that buffer's abort request at once.
// - In listen-only mode empty flags cannot be cleared; no transmission starts.
// - Buffer contents are blocked while the buffer is scheduled for transmission.
// - Empty flag writes: 1 clears, 0 leaves; only outside initialization.
// - In initialization the four transmit registers stay at reset values.
// - Enables and abort requests read anytime, written only outside initialization.
// - Each enable bit lets its buffer's empty condition raise the interrupt.
// - Software sets an abort request bit; it stays pending at 1.
// - Abort granted only before transmission starts or after a failed attempt.
// - Granted abort sets empty flag and abort acknowledge, raising enabled interrupt.
// - Writing 0 to abort requests is ignored; software cannot withdraw them.
// - Abort acknowledge is read-only; 1 aborted, 0 sent anyway.
// - Transmitter leaving bus-off for ok forces receiver state to ok.
// - Sensitivity codes: 00 none, 01 bus-off, 10 error or bus-off, 11 all.
module ctbsa_top (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Avalon-MM slave
	input wire logic [ctbsa_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Transmit engine
	input wire logic [ctbsa_pkg::NUM_BUF-1:0] i_tx_sent,
	input wire logic [ctbsa_pkg::NUM_BUF-1:0] i_tx_active,
	input wire logic [ctbsa_pkg::NUM_BUF-1:0] i_tx_failed,
	output logic [ctbsa_pkg::NUM_BUF-1:0] o_tx_pending,
	output logic [ctbsa_pkg::NUM_BUF-1:0] o_buf_blocked,
	// Protocol state
	input wire logic i_init_acknowledge,
	input wire logic [1:0] i_rx_state,
	input wire logic [1:0] i_tx_state,
	output logic o_init_request,
	output logic o_listen_only,
	output logic o_wakeup_irq_enable,
	output logic o_wakeup_function_enable,
	// Interrupt requests
	output logic o_tx_irq,
	output logic o_status_change_irq
);
	import ctbsa_pkg::*;

	// Decide whether a state change matters at the chosen sensitivity
	function automatic logic change_hits(input logic [1:0] sens, input logic [1:0] old_st,
		input logic [1:0] new_st);
		logic differs;
		differs = (old_st != new_st);
		unique case (sens)
			SENS_NONE: change_hits = 1'b0;
			SENS_BUS_OFF: change_hits = differs && (old_st == ST_BUS_OFF || new_st == ST_BUS_OFF);
			SENS_ERR: change_hits = differs && (old_st >= ST_ERR || new_st >= ST_ERR);
			SENS_ALL: change_hits = differs;
		endcase
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [NUM_BUF-1:0] tx_empty_flags;
	logic [NUM_BUF-1:0] tx_empty_irq_enables;
	logic [NUM_BUF-1:0] tx_abort_requests;
	logic [NUM_BUF-1:0] tx_abort_acks;
	logic [3:0] control;
	logic [3:0] sensitivity;
	logic [1:0] receiver_state_code;
	logic [1:0] tx_state_code;
	logic status_change_irq_flag;
	logic bus_ack;
	logic [NUM_BUF-1:0] next_empty_flags;
	logic [NUM_BUF-1:0] next_irq_enables;
	logic [NUM_BUF-1:0] next_abort_requests;
	logic [NUM_BUF-1:0] next_abort_acks;
	logic [1:0] next_rx_state;
	logic next_status_flag;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// Every access waits exactly one cycle so read data can be registered
	wire bus_req = i_avs_read | i_avs_write;
	wire wr_commit = i_avs_write & bus_ack & i_avs_byteenable[0];
	wire [7:0] wr_byte = i_avs_writedata[7:0];
	wire wr_flags = wr_commit && i_avs_address == OFS_EMPTY_FLAGS;
	wire wr_enables = wr_commit && i_avs_address == OFS_IRQ_ENABLES;
	wire wr_aborts = wr_commit && i_avs_address == OFS_ABORT_REQS;
	wire wr_control = wr_commit && i_avs_address == OFS_CONTROL;
	wire wr_status = wr_commit && i_avs_address == OFS_STATUS;
	wire wr_sens = wr_commit && i_avs_address == OFS_SENSITIVITY;
	assign o_avs_waitrequest = bus_req & ~bus_ack;

	// ------------------------------------------------------------
	// Mode qualifiers
	// ------------------------------------------------------------
	wire init_active = control[CTL_INIT_REQ] & i_init_acknowledge;
	wire init_idle = ~control[CTL_INIT_REQ] & ~i_init_acknowledge;
	wire listen_only = control[CTL_LISTEN];

	// ------------------------------------------------------------
	// Transmit buffer flag logic
	// ------------------------------------------------------------
	// Grant only to scheduled buffers not yet on the bus, or after a failed try
	wire [NUM_BUF-1:0] abort_grant = tx_abort_requests & ~tx_empty_flags &
		(~i_tx_active | i_tx_failed);
	wire [NUM_BUF-1:0] empty_set = (i_tx_sent & ~tx_empty_flags) | abort_grant;
	// Clears are dropped in listen-only mode and in any part of initialization
	wire [NUM_BUF-1:0] empty_clr = (wr_flags && init_idle && !listen_only) ?
		wr_byte[NUM_BUF-1:0] : '0;
	wire [NUM_BUF-1:0] abort_set = (wr_aborts && init_idle) ?
		wr_byte[NUM_BUF-1:0] & ~tx_empty_flags : '0;

	// Per-buffer next values; a hardware set always wins over a software clear
	generate
		for (genvar b = 0; b < NUM_BUF; b++) begin : g_buf
			assign next_empty_flags[b] = init_active ? RST_EMPTY_FLAGS[b] :
				(tx_empty_flags[b] & ~empty_clr[b]) | empty_set[b];
			assign next_abort_requests[b] = init_active ? RST_ABORT_REQS[b] :
				(tx_abort_requests[b] | abort_set[b]) & ~empty_set[b];
			assign next_abort_acks[b] = init_active ? RST_ABORT_ACKS[b] :
				(tx_abort_acks[b] & ~empty_clr[b]) | abort_grant[b];
			assign next_irq_enables[b] = init_active ? RST_IRQ_ENABLES[b] :
				((wr_enables && init_idle) ? wr_byte[b] : tx_empty_irq_enables[b]);
		end
	endgenerate

	// Transmit flag registers
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_empty_flags <= RST_EMPTY_FLAGS;
			tx_empty_irq_enables <= RST_IRQ_ENABLES;
			tx_abort_requests <= RST_ABORT_REQS;
			tx_abort_acks <= RST_ABORT_ACKS;
		end else begin
			tx_empty_flags <= next_empty_flags;
			tx_empty_irq_enables <= next_irq_enables;
			tx_abort_requests <= next_abort_requests;
			tx_abort_acks <= next_abort_acks;
		end
	end

	// Scheduling view for the engine and the buffer access path
	assign o_tx_pending = (listen_only || init_active) ? '0 : ~tx_empty_flags;
	assign o_buf_blocked = ~tx_empty_flags;
	assign o_tx_irq = |(tx_empty_flags & tx_empty_irq_enables);

	// ------------------------------------------------------------
	// Error state tracking and status change flag
	// ------------------------------------------------------------
	// Bus-off to ok on the transmitter drags the receiver back to ok too
	wire tx_recovered = tx_state_code == ST_BUS_OFF && i_tx_state == ST_OK;
	wire [1:0] rx_seen = tx_recovered ? ST_OK : i_rx_state;
	// Codes freeze while a change is pending so software sees what fired
	wire state_update = ~status_change_irq_flag;
	// The register packs the two codes as {rx, tx}, two bits lower than on the bus
	wire [1:0] rx_sens = sensitivity[SENS_RX_LSB-2 +: 2];
	wire [1:0] tx_sens = sensitivity[SENS_TX_LSB-2 +: 2];
	wire change_event = state_update &&
		(change_hits(rx_sens, receiver_state_code, rx_seen) ||
		change_hits(tx_sens, tx_state_code, i_tx_state));
	assign next_rx_state = state_update ? rx_seen : receiver_state_code;
	assign next_status_flag = change_event |
		(status_change_irq_flag & ~(wr_status & wr_byte[STA_CHANGE_FLAG]));

	// Status registers
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			receiver_state_code <= ST_OK;
			tx_state_code <= ST_OK;
			status_change_irq_flag <= 1'b0;
		end else begin
			receiver_state_code <= next_rx_state;
			tx_state_code <= state_update ? i_tx_state : tx_state_code;
			status_change_irq_flag <= next_status_flag;
		end
	end

	// Control and sensitivity; writable in any mode so init can be left
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			control <= RST_CONTROL;
			sensitivity <= RST_SENSITIVITY;
		end else begin
			control <= wr_control ? wr_byte[3:0] : control;
			sensitivity <= wr_sens ? {wr_byte[SENS_RX_LSB +: 2], wr_byte[SENS_TX_LSB +: 2]} :
				sensitivity;
		end
	end

	assign o_init_request = control[CTL_INIT_REQ];
	assign o_listen_only = listen_only;
	assign o_wakeup_irq_enable = control[CTL_WAKE_IRQ_EN];
	assign o_wakeup_function_enable = control[CTL_WAKE_FN_EN];
	assign o_status_change_irq = status_change_irq_flag;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Unmapped addresses read zero; abort acknowledge has no write path
	wire [7:0] status_byte = {1'b0, status_change_irq_flag, tx_state_code,
		receiver_state_code, 1'b0, i_init_acknowledge};
	wire [7:0] read_mux =
		(i_avs_address == OFS_EMPTY_FLAGS) ? {5'h00, tx_empty_flags} :
		(i_avs_address == OFS_IRQ_ENABLES) ? {5'h00, tx_empty_irq_enables} :
		(i_avs_address == OFS_ABORT_REQS) ? {5'h00, tx_abort_requests} :
		(i_avs_address == OFS_ABORT_ACKS) ? {5'h00, tx_abort_acks} :
		(i_avs_address == OFS_CONTROL) ? {4'h0, control} :
		(i_avs_address == OFS_STATUS) ? status_byte :
		(i_avs_address == OFS_SENSITIVITY) ? {2'h0, sensitivity, 2'h0} : 8'h00;

	// Bus handshake and registered read data
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bus_ack <= 1'b0;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
			o_avs_readdata <= (i_avs_read && !bus_ack) ? {24'h00_0000, read_mux} : o_avs_readdata;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	sent_sets_empty_a: assert property (
		(i_tx_sent[0] && !tx_empty_flags[0] && !init_active) |=> tx_empty_flags[0])
		else $error("sent message did not set empty flag");
	grant_sets_both_a: assert property (
		(abort_grant[1] && !init_active) |=> tx_empty_flags[1] && tx_abort_acks[1])
		else $error("granted abort did not set empty and acknowledge");
	abort_in_flight_a: assert property (
		(tx_abort_requests[2] && i_tx_active[2] && !i_tx_failed[2] && !i_tx_sent[2])
		|=> !tx_abort_acks[2] || $past(tx_abort_acks[2]))
		else $error("abort granted to a message on the bus");
	empty_drops_request_a: assert property (
		$rose(tx_empty_flags[0]) |-> !tx_abort_requests[0])
		else $error("abort request survived empty flag set");
	request_stays_set_a: assert property (
		(tx_abort_requests[1] && !tx_empty_flags[1] && !init_active) ##1 !init_active
		|-> tx_abort_requests[1] || tx_empty_flags[1])
		else $error("abort request withdrawn without empty flag");
	clear_drops_ack_a: assert property (
		$fell(tx_empty_flags[2]) |-> !tx_abort_acks[2])
		else $error("abort acknowledge survived empty clear");
	listen_blocks_clear_a: assert property (
		(listen_only && tx_empty_flags[1]) ##1 listen_only |-> tx_empty_flags[1])
		else $error("empty flag cleared in listen-only mode");
	init_holds_reset_a: assert property (
		init_active |=> tx_empty_flags == RST_EMPTY_FLAGS && tx_abort_acks == RST_ABORT_ACKS
		&& tx_empty_irq_enables == RST_IRQ_ENABLES && tx_abort_requests == RST_ABORT_REQS)
		else $error("transmit registers not held in initialization");
	irq_follows_flags_a: assert property (
		(tx_empty_flags[2] && tx_empty_irq_enables[2]) |-> o_tx_irq)
		else $error("transmit interrupt mismatch");
	rx_forced_ok_a: assert property (
		(state_update && tx_recovered) |=> receiver_state_code == ST_OK)
		else $error("receiver state not forced to ok");
	wait_one_cycle_a: assert property (
		$rose(bus_req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	// The acknowledge is a one-cycle pulse; a stuck one would commit writes twice
	ack_one_cycle_a: assert property (
		bus_ack |=> !bus_ack)
		else $error("bus acknowledge held too long");
	no_idle_ack_a: assert property (
		!bus_req |=> !bus_ack)
		else $error("bus acknowledge without request");
	read_upper_zero_a: assert property (
		o_avs_readdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");

	// ------------------------------------------------------------
	// Assertions on software writes
	// ------------------------------------------------------------
	// A write of one clears the flag unless the engine sets it in the same cycle
	clear_takes_effect_a: assert property (
		(wr_flags && init_idle && !listen_only && wr_byte[0] && !empty_set[0])
		|=> !tx_empty_flags[0])
		else $error("empty flag not cleared by one");
	zero_write_keeps_a: assert property (
		(wr_flags && !wr_byte[1] && tx_empty_flags[1]) |=> tx_empty_flags[1])
		else $error("empty flag cleared by zero");
	init_write_refused_a: assert property (
		(wr_flags && !init_idle && tx_empty_flags[2]) |=> tx_empty_flags[2])
		else $error("empty flag cleared in initialization");
	enable_write_a: assert property (
		(wr_enables && init_idle && wr_byte[0]) |=> tx_empty_irq_enables[0])
		else $error("enable write lost");
	enable_clear_a: assert property (
		(wr_enables && init_idle && !wr_byte[2]) |=> !tx_empty_irq_enables[2])
		else $error("enable not cleared by write");
	// Half-way through entering or leaving init the enables must not move at all
	enable_locked_a: assert property (
		(!init_idle && !init_active) |=> $stable(tx_empty_irq_enables))
		else $error("enables changed in initialization");
	abort_write_sets_a: assert property (
		(wr_aborts && init_idle && wr_byte[1] && !tx_empty_flags[1] && !empty_set[1])
		|=> tx_abort_requests[1])
		else $error("abort request write lost");
	// Only a grant, a flag clear or initialization may move an acknowledge
	ack_read_only_a: assert property (
		(wr_commit && i_avs_address == OFS_ABORT_ACKS && !init_active && abort_grant == '0)
		|=> $stable(tx_abort_acks))
		else $error("abort acknowledge changed by write");

	// ------------------------------------------------------------
	// Assertions on flag invariants
	// ------------------------------------------------------------
	// An abort request only ever stands against a scheduled buffer
	request_needs_full_a: assert property (
		(tx_abort_requests & tx_empty_flags) == '0)
		else $error("abort request on empty buffer");
	// An acknowledge is cleared with its flag, so it never outlives it
	ack_needs_empty_a: assert property (
		(tx_abort_acks & ~tx_empty_flags) == '0)
		else $error("abort acknowledge on scheduled buffer");
	pending_hidden_a: assert property (
		listen_only |-> o_tx_pending == '0)
		else $error("buffer offered in listen-only mode");
	blocked_when_full_a: assert property (
		!tx_empty_flags[1] |-> o_buf_blocked[1])
		else $error("scheduled buffer not blocked");
	irq_pending_a: assert property (
		(tx_empty_flags[0] && tx_empty_irq_enables[0]) |-> o_tx_irq)
		else $error("enabled empty buffer without interrupt");
	irq_needs_enable_a: assert property (
		tx_empty_irq_enables == '0 |-> !o_tx_irq)
		else $error("transmit interrupt without enable");

	// ------------------------------------------------------------
	// Assertions on the status change flag
	// ------------------------------------------------------------
	// A change seen in the same cycle as a software clear must still land
	change_sets_flag_a: assert property (
		change_event |=> status_change_irq_flag)
		else $error("state change lost its flag");
	codes_frozen_a: assert property (
		status_change_irq_flag |=> $stable(receiver_state_code) && $stable(tx_state_code))
		else $error("state codes moved while flag pending");
	quiet_when_none_a: assert property (
		(rx_sens == SENS_NONE && tx_sens == SENS_NONE && !status_change_irq_flag)
		|=> !status_change_irq_flag)
		else $error("status change with sensitivity off");
	bus_off_hits_a: assert property (
		(state_update && tx_sens == SENS_BUS_OFF && tx_state_code != ST_BUS_OFF
		&& i_tx_state == ST_BUS_OFF) |=> status_change_irq_flag)
		else $error("bus-off entry not flagged");
	// Lesser transmitter moves stay silent when only bus-off matters
	warn_ignored_a: assert property (
		(state_update && tx_sens == SENS_BUS_OFF && rx_sens == SENS_NONE
		&& tx_state_code != ST_BUS_OFF && i_tx_state != ST_BUS_OFF) |=> !status_change_irq_flag)
		else $error("minor state change flagged");

	abort_grant_c: cover property (abort_grant[2] ##1 tx_abort_acks[2]);
	send_cycle_c: cover property ($fell(tx_empty_flags[1]) ##[1:20] $rose(tx_empty_flags[1]));
	status_change_c: cover property ($rose(status_change_irq_flag));
	init_cycle_c: cover property (init_active ##[1:10] init_idle);
	listen_hold_c: cover property (listen_only && !tx_empty_flags[0]);

endmodule

// ==== ctbsa_engine_model.sv ====
module ctbsa_engine_model (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// From the block
	input wire logic i_init_request,
	input wire logic [ctbsa_pkg::NUM_BUF-1:0] i_tx_pending,
	// Bench commands
	input wire logic [ctbsa_pkg::NUM_BUF-1:0] i_cmd_sent,
	input wire logic [ctbsa_pkg::NUM_BUF-1:0] i_cmd_fail,
	input wire logic [ctbsa_pkg::NUM_BUF-1:0] i_cmd_active,
	input wire logic [1:0] i_cmd_tx_state,
	// To the block
	output logic [ctbsa_pkg::NUM_BUF-1:0] o_tx_sent,
	output logic [ctbsa_pkg::NUM_BUF-1:0] o_tx_active,
	output logic [ctbsa_pkg::NUM_BUF-1:0] o_tx_failed,
	output logic o_init_acknowledge,
	output logic [1:0] o_rx_state,
	output logic [1:0] o_tx_state
);
	timeunit 1ns;
	timeprecision 1ps;
	import ctbsa_pkg::*;

	// ------------------------------------------------------------
	// Protocol engine, one cycle behind every command
	// ------------------------------------------------------------
	// Only buffers the block offers may go on the bus, so a mode that hides them stops traffic
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_tx_sent <= '0;
			o_tx_active <= '0;
			o_tx_failed <= '0;
			o_init_acknowledge <= 1'b0;
			o_rx_state <= ST_OK;
			o_tx_state <= ST_OK;
		end else begin
			o_init_acknowledge <= i_init_request;
			o_tx_active <= i_cmd_active & i_tx_pending;
			o_tx_sent <= i_cmd_sent & i_tx_pending; // Sent only when scheduled
			o_tx_failed <= i_cmd_fail & i_tx_pending; // Lost arbitration or error
			o_tx_state <= i_cmd_tx_state;
			if (o_tx_state == ST_BUS_OFF && i_cmd_tx_state == ST_OK) begin
				o_rx_state <= ST_OK;
			end
		end
	end
endmodule

// ==== ctbsa_top_test.sv ====
module ctbsa_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ctbsa_pkg::*;

	// ------------------------------------------------------------
	// Stimulus, design and far-side model
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] be = 4'hf;
	logic [2:0] cmd_sent = '0;
	logic [2:0] cmd_fail = '0;
	logic [2:0] cmd_active = '0;
	logic [1:0] cmd_tx_st = ST_OK;
	logic [31:0] rdata;
	logic [31:0] readdata;
	logic waitreq, init_ack, init_req, listen, wk_irq, wk_fn, tx_irq, sc_irq;
	logic [2:0] tx_sent, tx_active, tx_failed, tx_pending, buf_blocked, exp_f, m, en;
	logic [1:0] rx_st, tx_st;
	int num_errors = 0;
	int cmp_count = 0;
	int seed = 32'h336d;
	int r;

	// Free-running system clock, 8 ns
	always #4 clk = ~clk;

	ctbsa_top ctbsa_top_inst (.i_sys_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(readdata), .o_avs_waitrequest(waitreq), .i_tx_sent(tx_sent),
		.i_tx_active(tx_active), .i_tx_failed(tx_failed), .o_tx_pending(tx_pending),
		.o_buf_blocked(buf_blocked), .i_init_acknowledge(init_ack), .i_rx_state(rx_st),
		.i_tx_state(tx_st), .o_init_request(init_req), .o_listen_only(listen),
		.o_wakeup_irq_enable(wk_irq), .o_wakeup_function_enable(wk_fn), .o_tx_irq(tx_irq),
		.o_status_change_irq(sc_irq));

	ctbsa_engine_model ctbsa_engine_model_inst (.i_sys_clk(clk), .i_reset_n(rst_n),
		.i_init_request(init_req), .i_tx_pending(tx_pending), .i_cmd_sent(cmd_sent),
		.i_cmd_fail(cmd_fail), .i_cmd_active(cmd_active), .i_cmd_tx_state(cmd_tx_st),
		.o_tx_sent(tx_sent), .o_tx_active(tx_active), .o_tx_failed(tx_failed),
		.o_init_acknowledge(init_ack), .o_rx_state(rx_st), .o_tx_state(tx_st));

	// ------------------------------------------------------------
	// Bus cycles, comparisons and closing
	// ------------------------------------------------------------
	// Request held until waitrequest is seen low, for at most 20 cycles; a slower answer counts as an error
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		if (waitreq !== 1'b0) num_errors++;
		rdata = readdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic check_reg(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		cmp_count++;
		if (rdata !== {24'h0, e}) begin
			num_errors++;
			$display("wrong value at %0t: reg %h read %h expected %h", $time, a, rdata, e);
		end
	endtask

	task automatic check_pin(input logic [2:0] got, input logic [2:0] e);
		cmp_count++;
		if (got !== e) begin
			num_errors++;
			$display("wrong value at %0t: pin %b expected %b", $time, got, e);
		end
	endtask

	// Pulse the engine commands; the flag lands two edges later
	task automatic engine(input logic [2:0] s, input logic [2:0] f);
		@(posedge clk);
		cmd_sent <= s;
		cmd_fail <= f;
		@(posedge clk);
		cmd_sent <= '0;
		cmd_fail <= '0;
		repeat (2) @(posedge clk);
	endtask

	function automatic logic exp_irq(input logic [2:0] f, input logic [2:0] e);
		return |(f & e);
	endfunction

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Watchdog sized far above the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict();
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		check_reg(OFS_EMPTY_FLAGS, {5'h0, RST_EMPTY_FLAGS});
		check_reg(OFS_ABORT_ACKS, {5'h0, RST_ABORT_ACKS});
		check_reg(5'h1c, 8'h00);
		bus(1'b1, OFS_IRQ_ENABLES, 8'h07);
		bus(1'b1, OFS_EMPTY_FLAGS, 8'h07);
		check_reg(OFS_IRQ_ENABLES, {5'h0, RST_IRQ_ENABLES});
		check_reg(OFS_EMPTY_FLAGS, 8'h07);
		bus(1'b1, OFS_CONTROL, 8'h00);
		repeat (3) @(posedge clk);
		exp_f = 3'h7;
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			m = r[2:0];
			en = r[5:3];
			bus(1'b1, OFS_EMPTY_FLAGS, {5'h0, m}); // Counted as loaded
			exp_f = exp_f & ~m;
			bus(1'b1, OFS_IRQ_ENABLES, {5'h0, en});
			check_reg(OFS_EMPTY_FLAGS, {5'h0, exp_f});
			check_reg(OFS_IRQ_ENABLES, {5'h0, en});
			check_pin({2'h0, tx_irq}, {2'h0, exp_irq(exp_f, en)});
			check_pin(buf_blocked, ~exp_f);
			check_pin(tx_pending, ~exp_f);
			m = r[8:6];
			engine(m, 3'h0);
			exp_f = exp_f | m;
			check_reg(OFS_EMPTY_FLAGS, {5'h0, exp_f});
		end
		// Abort: buffer 1 is on the bus, buffer 2 still waiting
		engine(3'h7, 3'h0);
		bus(1'b1, OFS_IRQ_ENABLES, 8'h02);
		bus(1'b1, OFS_EMPTY_FLAGS, 8'h06);
		cmd_active <= 3'h2;
		bus(1'b1, OFS_ABORT_REQS, 8'h07);
		check_reg(OFS_ABORT_REQS, 8'h02);
		check_reg(OFS_ABORT_ACKS, 8'h04);
		check_reg(OFS_EMPTY_FLAGS, 8'h05);
		bus(1'b1, OFS_ABORT_REQS, 8'h00);
		bus(1'b1, OFS_ABORT_ACKS, 8'h07);
		check_reg(OFS_ABORT_REQS, 8'h02);
		check_reg(OFS_ABORT_ACKS, 8'h04);
		engine(3'h0, 3'h2);
		check_reg(OFS_EMPTY_FLAGS, 8'h07);
		check_reg(OFS_ABORT_REQS, 8'h00);
		check_reg(OFS_ABORT_ACKS, 8'h06);
		check_pin({2'h0, tx_irq}, 3'h1);
		bus(1'b1, OFS_EMPTY_FLAGS, 8'h04);
		check_reg(OFS_ABORT_ACKS, 8'h02);
		// A message already on the bus goes out despite the request
		cmd_active <= 3'h4;
		bus(1'b1, OFS_ABORT_REQS, 8'h04);
		engine(3'h4, 3'h0);
		check_reg(OFS_ABORT_ACKS, 8'h02);
		check_reg(OFS_ABORT_REQS, 8'h00);
		cmd_active <= 3'h0;
		// Listen-only hides pending buffers and refuses clears
		bus(1'b1, OFS_EMPTY_FLAGS, 8'h01);
		bus(1'b1, OFS_CONTROL, 8'h0e); // Both wake-up enables together
		@(posedge clk);
		check_pin(tx_pending, 3'h0);
		check_pin({wk_irq, wk_fn, listen}, 3'h7);
		bus(1'b1, OFS_EMPTY_FLAGS, 8'h06);
		check_reg(OFS_EMPTY_FLAGS, 8'h06);
		// Transmitter sensitivity 01 reacts to bus-off only
		bus(1'b1, OFS_CONTROL, 8'h00);
		bus(1'b1, OFS_SENSITIVITY, 8'h04);
		cmd_tx_st <= ST_WARN;
		repeat (4) @(posedge clk);
		check_pin({2'h0, sc_irq}, 3'h0);
		cmd_tx_st <= ST_BUS_OFF;
		repeat (4) @(posedge clk);
		check_pin({2'h0, sc_irq}, 3'h1);
		check_reg(OFS_STATUS, 8'h70);
		bus(1'b1, OFS_STATUS, 8'h40);
		check_reg(OFS_STATUS, 8'h30);
		// All changes on both sides; leaving bus-off drags the receiver to ok
		bus(1'b1, OFS_SENSITIVITY, 8'h3c);
		cmd_tx_st <= ST_OK;
		repeat (4) @(posedge clk);
		check_reg(OFS_STATUS, 8'h40);
		// Back into initialization: the transmit flags, enables and acknowledges return to reset
		bus(1'b1, OFS_CONTROL, 8'h01);
		repeat (3) @(posedge clk);
		check_reg(OFS_EMPTY_FLAGS, {5'h0, RST_EMPTY_FLAGS});
		check_reg(OFS_IRQ_ENABLES, {5'h0, RST_IRQ_ENABLES});
		check_reg(OFS_ABORT_ACKS, {5'h0, RST_ABORT_ACKS});
		check_pin({2'h0, init_req}, 3'h1);
		give_verdict();
	end
endmodule
